// ---- ivu_interrupt_vector_unit.sv ----
// Added by the designer: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ps
// Operation
// - enabled external pulse vectors to address one
// - fast clock: pulse qualifies after 1.65us
// - slow clock: pulse qualifies after 13.3us
// - software picks input polarity and trigger edge
// - external input gates and measures 8-bit timer
// - power-on reset starts execution at zero
// - reset returns every port pin to input
// - wake-up released only by enabled ports
module ivu_interrupt_vector_unit (
   // clock and reset
   input logic mclk,
   input logic arst_n,
   // axi4-lite write
   input logic [ivu_pkg::ADDR_W-1:0] s_axi_awaddr,
   input logic s_axi_awvalid,
   output logic s_axi_awready,
   input logic [ivu_pkg::DATA_W-1:0] s_axi_wdata,
   input logic [ivu_pkg::STRB_W-1:0] s_axi_wstrb,
   input logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input logic s_axi_bready,
   // axi4-lite read
   input logic [ivu_pkg::ADDR_W-1:0] s_axi_araddr,
   input logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [ivu_pkg::DATA_W-1:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input logic s_axi_rready,
   // interrupt pin and wake sources
   input logic extIrqInput,
   input logic [ivu_pkg::PORT_N-1:0] portWakeIn,
   output logic wakeRelease,
   output logic [ivu_pkg::PORT_N-1:0] portOeN,
   // core vector handshake
   input logic vecAck,
   output ivu_pkg::ivu_vec_t vecOut,
   // serial unit side
   input logic serialDone,
   input logic serTxData,
   input logic serTxEn,
   output logic serRxData,
   // serial pin sets
   input logic serialPinSetOneRx,
   input logic serialPinSetTwoRx,
   output logic serialPinSetOneTx,
   output logic serialPinSetOneOeN,
   output logic serialPinSetTwoOeN
);
   typedef struct packed {
      logic [1:0] extSync;
      logic [1:0] oneSync;
      logic [1:0] twoSync;
      logic [ivu_pkg::PORT_N-1:0] actA;
      logic [ivu_pkg::PORT_N-1:0] actB;
      ivu_pkg::ivu_ctrl_t ctrl;
      logic [ivu_pkg::PORT_N-1:0] wakeEn;
      logic [ivu_pkg::PORT_N-1:0] portDir;
      logic [ivu_pkg::PORT_N-1:0] portOeN;
      logic extPend;
      logic serPend;
      ivu_pkg::ivu_fsm_t st;
      ivu_pkg::ivu_vec_t vec;
      logic [ivu_pkg::TIM_W-1:0] timer;
      logic [ivu_pkg::TIM_W-1:0] width;
      logic wake;
      logic rxSel;
      logic oneTx;
      logic oneOeN;
      logic twoOeN;
      logic awready;
      logic wready;
      logic awGot;
      logic wGot;
      logic [ivu_pkg::ADDR_W-1:0] awaddr;
      logic [ivu_pkg::DATA_W-1:0] wdata;
      logic [ivu_pkg::STRB_W-1:0] wstrb;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [ivu_pkg::DATA_W-1:0] rdata;
      logic [1:0] rresp;
   } ivu_regs_t;

   localparam int WORD_IDX = ivu_pkg::WORD_LSB;
   ivu_regs_t s_r;
   ivu_regs_t s_nxt;
   logic [1:0] rstSync_r;
   logic rstSyncN;
   logic qualLevel, qualRose, qualFell;
   logic extEvt, serEvt, wrDo, wrLow;
   logic [ivu_pkg::ADDR_W-1:WORD_IDX] wrIdx;
   logic [ivu_pkg::DATA_W+1:0] wrLook;
   logic swClrExt, swClrSer, timClr, ackExt, ackSer;

   // reset is released synchronously so every flop leaves reset on the same edge
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         rstSync_r <= 2'h0;
      end else begin
         rstSync_r <= {rstSync_r[0], 1'b1};
      end
   end
   assign rstSyncN = rstSync_r[1];

   ivu_pulse_qual u_qual (
      .clk(mclk),
      .rstN(rstSyncN),
      .rawIn(s_r.extSync[1] ^ s_r.ctrl.polInv),
      .slowSel(s_r.ctrl.slowClk),
      .level(qualLevel),
      .rose(qualRose),
      .fell(qualFell)
   );

   assign extEvt = s_r.ctrl.gie & s_r.ctrl.extEn & (s_r.ctrl.edgeFall ? qualFell : qualRose);
   assign serEvt = s_r.ctrl.gie & s_r.ctrl.serEn & serialDone;
   assign wrDo = s_r.awGot & s_r.wGot & ~s_r.bvalid;
   assign wrLow = wrDo & s_r.wstrb[0];
   assign wrIdx = s_r.awaddr[ivu_pkg::ADDR_W-1:WORD_IDX];
   assign swClrExt = wrLow & (wrIdx == ivu_pkg::OFF_STAT[ivu_pkg::ADDR_W-1:WORD_IDX])
                     & s_r.wdata[ivu_pkg::STAT_EXT];
   assign swClrSer = wrLow & (wrIdx == ivu_pkg::OFF_STAT[ivu_pkg::ADDR_W-1:WORD_IDX])
                     & s_r.wdata[ivu_pkg::STAT_SER];
   assign timClr = wrDo & (wrIdx == ivu_pkg::OFF_TIMER[ivu_pkg::ADDR_W-1:WORD_IDX]);
   assign ackExt = vecAck & s_r.vec.req & (s_r.st == ivu_pkg::ST_EXT);
   assign ackSer = vecAck & s_r.vec.req & (s_r.st == ivu_pkg::ST_SER);

   function automatic logic [ivu_pkg::DATA_W+1:0] readReg(input logic [ivu_pkg::ADDR_W-1:0] a);
      logic [ivu_pkg::DATA_W-1:0] d;
      logic [1:0] r;
      d = '0;
      r = ivu_pkg::RESP_OKAY;
      case (a[ivu_pkg::ADDR_W-1:WORD_IDX])
         ivu_pkg::OFF_CTRL[ivu_pkg::ADDR_W-1:WORD_IDX]: d[ivu_pkg::CTRL_W-1:0] = s_r.ctrl;
         ivu_pkg::OFF_STAT[ivu_pkg::ADDR_W-1:WORD_IDX]: begin
            d[ivu_pkg::STAT_EXT] = s_r.extPend;
            d[ivu_pkg::STAT_SER] = s_r.serPend;
            d[ivu_pkg::STAT_REQ] = s_r.vec.req;
         end
         ivu_pkg::OFF_WAKE[ivu_pkg::ADDR_W-1:WORD_IDX]: d[ivu_pkg::PORT_N-1:0] = s_r.wakeEn;
         ivu_pkg::OFF_TIMER[ivu_pkg::ADDR_W-1:WORD_IDX]: begin
            d[ivu_pkg::TIM_CNT_LSB +: ivu_pkg::TIM_W] = s_r.timer;
            d[ivu_pkg::TIM_CAPT_LSB +: ivu_pkg::TIM_W] = s_r.width;
         end
         ivu_pkg::OFF_PDIR[ivu_pkg::ADDR_W-1:WORD_IDX]: d[ivu_pkg::PORT_N-1:0] = s_r.portDir;
         default: r = ivu_pkg::RESP_SLVERR;
      endcase
      return {r, d};
   endfunction

   always_comb begin
      s_nxt = s_r;
      wrLook = readReg(s_r.awaddr);
      // pin synchronisers
      s_nxt.extSync = {s_r.extSync[0], extIrqInput};
      s_nxt.oneSync = {s_r.oneSync[0], serialPinSetOneRx};
      s_nxt.twoSync = {s_r.twoSync[0], serialPinSetTwoRx};
      s_nxt.actA = portWakeIn;
      s_nxt.actB = s_r.actA;
      s_nxt.wake = |(s_r.actB & s_r.wakeEn);
      // serial pin set steering; set two is open drain and only ever pulls low
      s_nxt.rxSel = s_r.ctrl.pinSetTwo ? s_r.twoSync[1] : s_r.oneSync[1];
      s_nxt.oneTx = serTxData;
      s_nxt.oneOeN = ~(~s_r.ctrl.pinSetTwo & serTxEn);
      s_nxt.twoOeN = ~(s_r.ctrl.pinSetTwo & serTxEn & ~serTxData);
      s_nxt.portOeN = ~s_r.portDir;
      // gated timer: counts while the qualified input is active, captured at its end
      if (timClr) begin
         s_nxt.timer = '0;
      end else if (s_r.ctrl.gateEn & qualLevel) begin
         s_nxt.timer = ivu_pkg::TIM_W'(s_r.timer + 1'b1);
      end
      if (s_r.ctrl.gateEn & qualFell) begin
         s_nxt.width = s_r.timer;
      end
      // a new event beats a clear in the same cycle
      s_nxt.extPend = (s_r.extPend & ~(swClrExt | ackExt)) | extEvt;
      s_nxt.serPend = (s_r.serPend & ~(swClrSer | ackSer)) | serEvt;
      unique case (s_r.st)
         ivu_pkg::ST_RST: begin
            if (vecAck) begin
               s_nxt.st = ivu_pkg::ST_IDLE;
               s_nxt.vec.req = 1'b0;
            end
         end
         ivu_pkg::ST_IDLE: begin
            if (s_r.extPend) begin
               s_nxt.st = ivu_pkg::ST_EXT;
               s_nxt.vec = '{req: 1'b1, addr: ivu_pkg::VEC_EXT};
            end else if (s_r.serPend) begin
               s_nxt.st = ivu_pkg::ST_SER;
               s_nxt.vec = '{req: 1'b1, addr: ivu_pkg::VEC_SER};
            end
         end
         ivu_pkg::ST_EXT, ivu_pkg::ST_SER: begin
            if (vecAck) begin
               s_nxt.st = ivu_pkg::ST_IDLE;
               s_nxt.vec.req = 1'b0;
            end
         end
      endcase
      // write channel: address and data may arrive in either order
      if (s_axi_awvalid & s_r.awready) begin
         s_nxt.awGot = 1'b1;
         s_nxt.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid & s_r.wready) begin
         s_nxt.wGot = 1'b1;
         s_nxt.wdata = s_axi_wdata;
         s_nxt.wstrb = s_axi_wstrb;
      end
      if (wrDo) begin
         s_nxt.awGot = 1'b0;
         s_nxt.wGot = 1'b0;
         s_nxt.bvalid = 1'b1;
         s_nxt.bresp = wrLook[ivu_pkg::DATA_W+1:ivu_pkg::DATA_W];
         if (wrLow) begin
            unique case (wrIdx)
               ivu_pkg::OFF_CTRL[ivu_pkg::ADDR_W-1:WORD_IDX]:
                  s_nxt.ctrl = ivu_pkg::ivu_ctrl_t'(s_r.wdata[ivu_pkg::CTRL_W-1:0]);
               ivu_pkg::OFF_WAKE[ivu_pkg::ADDR_W-1:WORD_IDX]:
                  s_nxt.wakeEn = s_r.wdata[ivu_pkg::PORT_N-1:0];
               ivu_pkg::OFF_PDIR[ivu_pkg::ADDR_W-1:WORD_IDX]:
                  s_nxt.portDir = s_r.wdata[ivu_pkg::PORT_N-1:0];
               default: ;
            endcase
         end
      end else if (s_r.bvalid & s_axi_bready) begin
         s_nxt.bvalid = 1'b0;
      end
      s_nxt.awready = ~s_nxt.awGot & ~s_nxt.bvalid;
      s_nxt.wready = ~s_nxt.wGot & ~s_nxt.bvalid;
      // read channel: one read at a time, data one cycle after the address
      if (s_axi_arvalid & s_r.arready) begin
         s_nxt.rvalid = 1'b1;
         {s_nxt.rresp, s_nxt.rdata} = readReg(s_axi_araddr);
      end else if (s_r.rvalid & s_axi_rready) begin
         s_nxt.rvalid = 1'b0;
      end
      s_nxt.arready = ~s_nxt.rvalid;
   end

   always_ff @(posedge mclk or negedge rstSyncN) begin
      if (!rstSyncN) begin
         s_r <= '0;
         s_r.st <= ivu_pkg::ST_RST;
         s_r.vec <= '{req: 1'b1, addr: ivu_pkg::VEC_RESET};
         s_r.portOeN <= '1;
         s_r.oneOeN <= 1'b1;
         s_r.twoOeN <= 1'b1;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign s_axi_awready = s_r.awready;
   assign s_axi_wready = s_r.wready;
   assign s_axi_bresp = s_r.bresp;
   assign s_axi_bvalid = s_r.bvalid;
   assign s_axi_arready = s_r.arready;
   assign s_axi_rdata = s_r.rdata;
   assign s_axi_rresp = s_r.rresp;
   assign s_axi_rvalid = s_r.rvalid;
   assign wakeRelease = s_r.wake;
   assign portOeN = s_r.portOeN;
   assign vecOut = s_r.vec;
   assign serRxData = s_r.rxSel;
   assign serialPinSetOneTx = s_r.oneTx;
   assign serialPinSetOneOeN = s_r.oneOeN;
   assign serialPinSetTwoOeN = s_r.twoOeN;

   default clocking cbMain @(posedge mclk);
   endclocking
   default disable iff (!rstSyncN);

   sequence sExtReady;
      (s_r.st == ivu_pkg::ST_IDLE) && s_r.extPend;
   endsequence
   sequence sBoth;
      sExtReady ##0 (s_r.serPend && !swClrSer && !ackSer);
   endsequence

   property p_extVector;
      sExtReady |=> (vecOut.req && vecOut.addr == ivu_pkg::VEC_EXT) [*1] ##1 1'b1;
   endproperty
   a_extVector: assert property (p_extVector) else $error("external vector not raised");
   property p_edgeSel;
      extEvt |-> (s_r.ctrl.edgeFall ? !qualLevel : qualLevel) ##1 s_r.extPend;
   endproperty
   a_edgeSel: assert property (p_edgeSel) else $error("wrong trigger edge");
   property p_timerGate;
      (s_r.ctrl.gateEn && qualLevel && !timClr)
         |=> (s_r.timer == ivu_pkg::TIM_W'($past(s_r.timer) + 1'b1));
   endproperty
   a_timerGate: assert property (p_timerGate) else $error("gated timer stalled");
   property p_serVector;
      serEvt |=> s_r.serPend ##[0:300] (vecOut.req && vecOut.addr == ivu_pkg::VEC_SER);
   endproperty
   a_serVector: assert property (p_serVector) else $error("serial vector missing");
   property p_resetVector;
      (s_r.st == ivu_pkg::ST_RST) |-> (vecOut.req && vecOut.addr == ivu_pkg::VEC_RESET);
   endproperty
   a_resetVector: assert property (p_resetVector) else $error("reset vector not zero");
   property p_pinsInput;
      $rose(rstSyncN) |-> (portOeN == '1 && serialPinSetOneOeN && serialPinSetTwoOeN);
   endproperty
   a_pinsInput: assert property (p_pinsInput) else $error("pins not input after reset");
   property p_wake;
      (|(s_r.actB & s_r.wakeEn)) |=> wakeRelease;
   endproperty
   a_wake: assert property (p_wake) else $error("wake not released");
   property p_noWake;
      !(|(s_r.actB & s_r.wakeEn)) |=> !wakeRelease;
   endproperty
   a_noWake: assert property (p_noWake) else $error("wake from disabled port");
   property p_pinSet;
      (!s_r.ctrl.pinSetTwo) [*2] |-> serialPinSetTwoOeN;
   endproperty
   a_pinSet: assert property (p_pinSet) else $error("unselected pin set driven");
   property p_priority;
      sBoth |=> (vecOut.addr == ivu_pkg::VEC_EXT && s_r.serPend);
   endproperty
   a_priority: assert property (p_priority) else $error("serial served before external");
endmodule // ivu_interrupt_vector_unit

// ---- ivu_pkg.sv ----
package ivu_pkg;
   // timing
   localparam int CLK_PERIOD_NS = 40;
   localparam int EXT_MIN_FAST_NS = 1650;
   localparam int EXT_MIN_SLOW_NS = 13300;
   localparam int EXT_MIN_FAST_CYC = (EXT_MIN_FAST_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int EXT_MIN_SLOW_CYC = (EXT_MIN_SLOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int QCNT_W = 9;
   localparam logic [QCNT_W-1:0] QLIM_FAST = QCNT_W'(EXT_MIN_FAST_CYC - 1);
   localparam logic [QCNT_W-1:0] QLIM_SLOW = QCNT_W'(EXT_MIN_SLOW_CYC - 1);

   // vectors
   localparam int PC_W = 13;
   localparam logic [PC_W-1:0] VEC_RESET = 13'h0000;
   localparam logic [PC_W-1:0] VEC_EXT = 13'h0001;
   localparam logic [PC_W-1:0] VEC_SER = 13'h0004;

   // register bus
   localparam int ADDR_W = 8;
   localparam int DATA_W = 32;
   localparam int STRB_W = DATA_W / 8;
   localparam int WORD_LSB = 2;
   localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFF_STAT = 8'h04;
   localparam logic [ADDR_W-1:0] OFF_WAKE = 8'h08;
   localparam logic [ADDR_W-1:0] OFF_TIMER = 8'h0c;
   localparam logic [ADDR_W-1:0] OFF_PDIR = 8'h10;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // status and timer fields
   localparam int STAT_EXT = 0;
   localparam int STAT_SER = 1;
   localparam int STAT_REQ = 2;
   localparam int TIM_W = 8;
   localparam int TIM_CNT_LSB = 0;
   localparam int TIM_CAPT_LSB = 8;
   localparam int PORT_N = 8;

   typedef enum logic [1:0] {
      ST_IDLE = 2'h0,
      ST_EXT = 2'h1,
      ST_SER = 2'h2,
      ST_RST = 2'h3
   } ivu_fsm_t;

   typedef struct packed {
      logic pinSetTwo;
      logic gateEn;
      logic slowClk;
      logic edgeFall;
      logic polInv;
      logic serEn;
      logic extEn;
      logic gie;
   } ivu_ctrl_t;

   localparam int CTRL_W = $bits(ivu_ctrl_t);

   typedef struct packed {
      logic req;
      logic [PC_W-1:0] addr;
   } ivu_vec_t;
endpackage

// ---- ivu_pulse_qual.sv ----
`timescale 1ns/1ps
module ivu_pulse_qual (
   // clock and reset
   input logic clk,
   input logic rstN,
   // filter input and mode
   input logic rawIn,
   input logic slowSel,
   // filtered level and its edges
   output logic level,
   output logic rose,
   output logic fell
);
   typedef struct packed {
      logic [ivu_pkg::QCNT_W-1:0] cnt;
      logic level;
      logic rose;
      logic fell;
   } ivu_qual_t;

   ivu_qual_t s_r;
   ivu_qual_t s_nxt;
   logic [ivu_pkg::QCNT_W-1:0] lim;

   assign lim = slowSel ? ivu_pkg::QLIM_SLOW : ivu_pkg::QLIM_FAST;

   // a glitch shorter than the limit restarts the count, so it never reaches the core
   always_comb begin
      s_nxt = s_r;
      s_nxt.rose = 1'b0;
      s_nxt.fell = 1'b0;
      if (rawIn == s_r.level) begin
         s_nxt.cnt = '0;
      end else if (s_r.cnt >= lim) begin
         s_nxt.cnt = '0;
         s_nxt.level = rawIn;
         s_nxt.rose = rawIn;
         s_nxt.fell = ~rawIn;
      end else begin
         s_nxt.cnt = ivu_pkg::QCNT_W'(s_r.cnt + 1'b1);
      end
   end

   always_ff @(posedge clk or negedge rstN) begin
      if (!rstN) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign level = s_r.level;
   assign rose = s_r.rose;
   assign fell = s_r.fell;

   property p_fastWidth;
      @(posedge clk) disable iff (!rstN)
         ($changed(s_r.level) && !$past(slowSel)) |-> ($past(s_r.cnt) == ivu_pkg::QLIM_FAST);
   endproperty
   a_fastWidth: assert property (p_fastWidth) else $error("fast filter width wrong");

   property p_slowWidth;
      @(posedge clk) disable iff (!rstN)
         ($changed(s_r.level) && $past(slowSel)) |-> ($past(s_r.cnt) == ivu_pkg::QLIM_SLOW);
   endproperty
   a_slowWidth: assert property (p_slowWidth) else $error("slow filter width wrong");
endmodule // ivu_pulse_qual

// ---- ivu_ext_src.sv ----
`timescale 1ns/1ps
module ivu_ext_src (
   // clock
   input logic mclk,
   // command from the bench
   input logic go,
   input logic idleLvl,
   input logic [15:0] widthCyc,
   // interrupt pin
   output logic pinOut,
   output logic busy
);
   logic [15:0] cnt;
   initial begin
      busy = 1'b0;
      cnt = '0;
   end
   // the pin is always driven by the source, so no released state exists
   assign pinOut = busy ^ idleLvl;
   // the pulse stands for the full commanded count, never cut short
   always @(posedge mclk) begin
      if (go && !busy) begin
         busy <= 1'b1;
         cnt <= widthCyc;
      end else if (busy) begin
         cnt <= cnt - 16'h0001;
         if (cnt == 16'h0001)
            busy <= 1'b0;
      end
   end
endmodule // ivu_ext_src

// ---- tb_interrupt_vector_unit.sv ----
`timescale 1ns/1ps
module tb_interrupt_vector_unit;
   logic mclk, arst_n, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
   logic s_axi_rready, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, extIrqInput, wakeRelease, vecAck, serialDone, serTxData;
   logic serTxEn, serRxData, serialPinSetOneRx, serialPinSetTwoRx, serialPinSetOneTx;
   logic serialPinSetOneOeN, serialPinSetTwoOeN, go, idleLvl, busy;
   logic [7:0] s_axi_awaddr, s_axi_araddr, portWakeIn, portOeN;
   logic [31:0] s_axi_wdata, s_axi_rdata, rd;
   logic [3:0] s_axi_wstrb;
   logic [1:0] s_axi_bresp, s_axi_rresp, resp;
   logic [15:0] width;
   ivu_pkg::ivu_vec_t vecOut;
   int failures = 0;
   int n_checks = 0;
   ivu_interrupt_vector_unit u_ivu_interrupt_vector_unit (
      .mclk, .arst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
      .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .extIrqInput, .portWakeIn,
      .wakeRelease, .portOeN, .vecAck, .vecOut, .serialDone, .serTxData, .serTxEn,
      .serRxData, .serialPinSetOneRx, .serialPinSetTwoRx, .serialPinSetOneTx,
      .serialPinSetOneOeN, .serialPinSetTwoOeN
   );
   ivu_ext_src u_ivu_ext_src (
      .mclk, .go, .idleLvl, .widthCyc(width), .pinOut(extIrqInput), .busy
   );
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   task automatic end_of_test();
      $display("checks %0d, failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string m);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("wrong value at %0t: %s seen %h expected %h", $time, m, seen, exp);
      end
   endtask
   task automatic tmo(input int i, input int lim);
      if (i >= lim) begin
         failures++;
         end_of_test();
      end
   endtask
   task automatic axiWr(input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge mclk);
         if (s_axi_awready)
            s_axi_awvalid <= 1'b0;
         if (s_axi_wready)
            s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid)
            break;
      end
      s_axi_bready <= 1'b0;
      resp = s_axi_bresp;
      tmo(i, 50);
   endtask
   task automatic axiRd(input logic [7:0] a);
      int i;
      @(posedge mclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (i = 0; i < 50; i++) begin
         @(posedge mclk);
         if (s_axi_arready)
            s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid)
            break;
      end
      s_axi_rready <= 1'b0;
      rd = s_axi_rdata;
      resp = s_axi_rresp;
      tmo(i, 50);
   endtask
   task automatic pulse(input int w);
      @(posedge mclk);
      width <= 16'(w);
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      repeat (w + 10) @(posedge mclk);
   endtask
   // the ack is held one edge, then one more edge lets the next vector settle
   task automatic takeVec(input logic [12:0] a);
      int i;
      for (i = 0; i < 900; i++) begin
         @(posedge mclk);
         if (vecOut.req === 1'b1)
            break;
      end
      tmo(i, 900);
      chk(32'(vecOut.addr), 32'(a), "vector address");
      vecAck <= 1'b1;
      @(posedge mclk);
      vecAck <= 1'b0;
      @(posedge mclk);
   endtask
   task automatic doRst();
      arst_n <= 1'b0;
      repeat (8) @(posedge mclk);
      arst_n <= 1'b1;
      repeat (3) @(posedge mclk);
   endtask
   task automatic tOrder();
      chk(32'(portOeN), 32'hff, "ports input");
      chk({30'h0, serialPinSetOneOeN, serialPinSetTwoOeN}, 32'h3, "ser oe");
      axiWr(8'h00, 32'h07);
      @(posedge mclk);
      serialDone <= 1'b1;
      @(posedge mclk);
      serialDone <= 1'b0;
      pulse(50);
      takeVec(13'h0);
      takeVec(13'h1);
      axiRd(8'h04);
      chk(rd & 32'h2, 32'h2, "ser pending");
      takeVec(13'h4);
      @(posedge mclk);
      chk(32'(vecOut.req), 32'h0, "idle");
      $display("order test done");
   endtask
   task automatic tExt();
      // the filtered level must be back low, or the next pulse makes no edge at all
      repeat (50) @(posedge mclk);
      axiWr(8'h00, 32'h02);
      pulse(50);
      repeat (50) @(posedge mclk);
      axiRd(8'h04);
      chk(rd & 32'h1, 32'h0, "global off");
      axiWr(8'h00, 32'h03);
      pulse(41);
      repeat (50) @(posedge mclk);
      axiRd(8'h04);
      chk(rd & 32'h1, 32'h0, "short pulse");
      pulse(42);
      takeVec(13'h1);
      repeat (50) @(posedge mclk);
      axiWr(8'h00, 32'h23);
      pulse(332);
      repeat (20) @(posedge mclk);
      axiRd(8'h04);
      chk(rd & 32'h1, 32'h0, "slow short");
      pulse(333);
      takeVec(13'h1);
      repeat (400) @(posedge mclk);
      $display("pulse width test done");
   endtask
   task automatic tEdge();
      axiWr(8'h00, 32'h13);
      @(posedge mclk);
      width <= 16'd200;
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      repeat (100) @(posedge mclk);
      axiRd(8'h04);
      chk(rd & 32'h1, 32'h0, "rise ignored");
      takeVec(13'h1);
      axiWr(8'h00, 32'h00);
      idleLvl <= 1'b1;
      repeat (60) @(posedge mclk);
      axiWr(8'h00, 32'h0b);
      repeat (60) @(posedge mclk);
      axiWr(8'h04, 32'h03);
      pulse(50);
      takeVec(13'h1);
      axiWr(8'h00, 32'h00);
      idleLvl <= 1'b0;
      repeat (60) @(posedge mclk);
      $display("edge test done");
   endtask
   task automatic tMisc();
      axiWr(8'h00, 32'h40);
      axiWr(8'h0c, 32'h00);
      pulse(100);
      repeat (60) @(posedge mclk);
      axiRd(8'h0c);
      chk(32'(rd[15:8] inside {[8'd99:8'd101]}), 32'h1, "gate width");
      axiWr(8'h08, 32'h01);
      portWakeIn <= 8'h02;
      repeat (6) @(posedge mclk);
      chk(32'(wakeRelease), 32'h0, "wake masked");
      portWakeIn <= 8'h01;
      repeat (6) @(posedge mclk);
      chk(32'(wakeRelease), 32'h1, "wake enabled");
      axiWr(8'h00, 32'h00);
      serTxEn <= 1'b1;
      serialPinSetOneRx <= 1'b1;
      repeat (6) @(posedge mclk);
      chk({29'h0, serialPinSetOneOeN, serialPinSetTwoOeN, serRxData}, 32'h3, "set one");
      axiWr(8'h00, 32'h80);
      repeat (6) @(posedge mclk);
      chk({29'h0, serialPinSetOneOeN, serialPinSetTwoOeN, serRxData}, 32'h4, "set two");
      serTxData <= 1'b1;
      repeat (3) @(posedge mclk);
      chk({30'h0, serialPinSetOneTx, serialPinSetTwoOeN}, 32'h3, "tx copy, drain off");
      serTxData <= 1'b0;
      serTxEn <= 1'b0;
      $display("timer wake pin test done");
   endtask
   task automatic tBus();
      axiRd(8'h20);
      chk({rd[29:0], resp}, 32'h2, "unmapped read");
      axiWr(8'h20, 32'h01);
      chk(32'(resp), 32'h2, "unmapped write");
      axiWr(8'h10, 32'hff);
      repeat (2) @(posedge mclk);
      chk(32'(portOeN), 32'h00, "ports output");
      doRst();
      chk(32'(portOeN), 32'hff, "ports input again");
      chk(32'(vecOut), 32'h2000, "reset vector");
      takeVec(13'h0);
      $display("bus and reset test done");
   endtask
   initial begin
      {arst_n, go, idleLvl, vecAck, serialDone, serTxData, serTxEn} = '0;
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
      {serialPinSetOneRx, serialPinSetTwoRx, portWakeIn, width} = '0;
      s_axi_wstrb = 4'hf;
      doRst();
      tOrder();
      tExt();
      tEdge();
      tMisc();
      tBus();
      end_of_test();
   end
endmodule // tb_interrupt_vector_unit
